// ===== include/rsec_pkg.sv
package rsec_pkg;

  // bus geometry
  localparam int          ADDR_W      = 16;
  localparam int          DATA_W      = 32;
  localparam int          IDX_W       = 14;
  localparam int          ADDR_LSB    = 2;
  localparam logic [1:0]  ALIGN_OK    = 2'h0;

  // register indices, byte address is four times the index
  localparam logic [13:0] IDX_IO_UPDATE   = 14'h0005;
  localparam logic [13:0] IDX_REF_AB      = 14'h0D0B;
  localparam logic [13:0] IDX_REF_CD      = 14'h0D0C;
  localparam logic [13:0] IDX_TUNE_B0     = 14'h0D0D;
  localparam logic [13:0] IDX_TUNE_B1     = 14'h0D0E;
  localparam logic [13:0] IDX_TUNE_B2     = 14'h0D0F;
  localparam logic [13:0] IDX_TUNE_B3     = 14'h0D10;
  localparam logic [13:0] IDX_PHASE_LO    = 14'h0D11;
  localparam logic [13:0] IDX_PHASE_HI    = 14'h0D12;
  localparam logic [13:0] IDX_FREQ_LO     = 14'h0D13;
  localparam logic [13:0] IDX_FREQ_HI     = 14'h0D14;
  localparam logic [13:0] IDX_EE_WPROT    = 14'h0E00;
  localparam logic [13:0] IDX_EE_COND     = 14'h0E01;
  localparam logic [13:0] IDX_IRQ_STATUS  = 14'h0E08;
  localparam logic [13:0] IDX_IRQ_MASK    = 14'h0E09;

  // reference status nibble layout
  localparam int          NUM_REF     = 4;
  localparam int          NIB_W       = 4;
  localparam int          BIT_VALID   = 3;
  localparam int          BIT_FAULT   = 2;
  localparam int          BIT_FAST    = 1;
  localparam int          BIT_SLOW    = 0;

  // data widths
  localparam int          BYTE_W      = 8;
  localparam int          TUNE_W      = 30;
  localparam int          TUB_W       = 12;
  localparam int          COND_W      = 4;
  localparam int          IRQ_W       = 8;
  localparam int          IRQ_VAL_LSB = 4;

  // control bit positions and reset values
  localparam int          IO_UPDATE_BIT = 0;
  localparam int          WPROT_BIT     = 0;
  localparam logic        WPROT_RESET   = 1'b0;
  localparam logic [3:0]  COND_RESET    = 4'h0;
  localparam logic [7:0]  IRQ_RESET     = 8'h00;

endpackage : rsec_pkg

// ===== hw/rsec_regs.sv
// Notes on behaviour
// - valid means unfaulted and validation timer expired
// - fault bit set while input unusable
// - fast bit set above profile upper limit
// - slow bit set below profile lower limit
// - missing clock reports fast and slow together
// - status bytes refresh only on update strobe
// - 30-bit tuning word, four bytes, LSB first
// - 12-bit phase tub level, high nibble
// - 12-bit frequency tub level, high nibble
// - write protect live, reset blocks writes
// - live four-bit download condition, resets zero
module rsec_regs
(
  // clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_sys_rst,
  // apb slave
  input  wire logic                          i_psel,
  input  wire logic                          i_penable,
  input  wire logic                          i_pwrite,
  input  wire logic [rsec_pkg::ADDR_W-1:0]   i_paddr,
  input  wire logic [rsec_pkg::DATA_W-1:0]   i_pwdata,
  input  wire logic [3:0]                    i_pstrb,
  output logic      [rsec_pkg::DATA_W-1:0]   o_prdata,
  output logic                               o_pready,
  output logic                               o_pslverr,
  // reference monitors, same clock domain
  input  wire logic [rsec_pkg::NUM_REF-1:0]  i_ref_fault,
  input  wire logic [rsec_pkg::NUM_REF-1:0]  i_ref_timer_done,
  input  wire logic [rsec_pkg::NUM_REF-1:0]  i_ref_freq_high,
  input  wire logic [rsec_pkg::NUM_REF-1:0]  i_ref_freq_low,
  input  wire logic [rsec_pkg::NUM_REF-1:0]  i_ref_clk_missing,
  // controlled_oscillator history and lock detectors
  input  wire logic [rsec_pkg::TUNE_W-1:0]   i_tuning_word,
  input  wire logic [rsec_pkg::TUB_W-1:0]    i_phase_tub,
  input  wire logic [rsec_pkg::TUB_W-1:0]    i_freq_tub,
  // eeprom control and interrupt
  output logic                               o_eeprom_write_enable,
  output logic      [rsec_pkg::COND_W-1:0]   o_eeprom_download_condition,
  output logic                               o_io_update,
  output logic                               o_irq
);

  logic [rsec_pkg::IDX_W-1:0]   idx;
  logic                         aligned;
  logic                         setup_ph;
  logic                         access_ph;
  logic                         wr_en;
  logic                         io_update;
  logic                         hit;
  logic [rsec_pkg::BYTE_W-1:0]  rd_byte;
  logic [rsec_pkg::DATA_W-1:0]  prdata;
  logic                         err;
  logic [rsec_pkg::NIB_W-1:0]   ref_stat [rsec_pkg::NUM_REF];
  logic [rsec_pkg::NIB_W-1:0]   next_stat [rsec_pkg::NUM_REF];
  logic [rsec_pkg::TUNE_W-1:0]  tune;
  logic [rsec_pkg::TUB_W-1:0]   phase_tub;
  logic [rsec_pkg::TUB_W-1:0]   freq_tub;
  logic                         wprot;
  logic [rsec_pkg::COND_W-1:0]  cond;
  logic [rsec_pkg::NUM_REF-1:0] live_valid;
  logic [rsec_pkg::NUM_REF-1:0] prev_valid;
  logic [rsec_pkg::NUM_REF-1:0] prev_fault;
  logic [rsec_pkg::IRQ_W-1:0]   irq_set;
  logic [rsec_pkg::IRQ_W-1:0]   irq_status;
  logic [rsec_pkg::IRQ_W-1:0]   irq_mask;

  // zero wait states: read data is prepared during the setup phase
  assign idx       = i_paddr[rsec_pkg::ADDR_W-1:rsec_pkg::ADDR_LSB];
  assign aligned   = (i_paddr[rsec_pkg::ADDR_LSB-1:0] == rsec_pkg::ALIGN_OK);
  assign setup_ph  = i_psel & ~i_penable;
  assign access_ph = i_psel & i_penable;
  assign wr_en     = access_ph & i_pwrite & aligned & hit & i_pstrb[0];
  assign io_update = wr_en & (idx == rsec_pkg::IDX_IO_UPDATE)
                   & i_pwdata[rsec_pkg::IO_UPDATE_BIT];

  assign o_pready    = 1'b1;
  assign o_pslverr   = access_ph & err;
  assign o_prdata    = prdata;
  assign o_io_update = io_update;

  // read decode, reserved bits stay zero
  always_comb
  begin
    hit     = 1'b1;
    rd_byte = '0;
    unique case (idx)
      rsec_pkg::IDX_IO_UPDATE:  rd_byte = '0;
      rsec_pkg::IDX_REF_AB:     rd_byte = {ref_stat[1], ref_stat[0]};
      rsec_pkg::IDX_REF_CD:     rd_byte = {ref_stat[3], ref_stat[2]};
      rsec_pkg::IDX_TUNE_B0:    rd_byte = tune[7:0];
      rsec_pkg::IDX_TUNE_B1:    rd_byte = tune[15:8];
      rsec_pkg::IDX_TUNE_B2:    rd_byte = tune[23:16];
      rsec_pkg::IDX_TUNE_B3:    rd_byte = {2'h0, tune[29:24]};
      rsec_pkg::IDX_PHASE_LO:   rd_byte = phase_tub[7:0];
      rsec_pkg::IDX_PHASE_HI:   rd_byte = {4'h0, phase_tub[11:8]};
      rsec_pkg::IDX_FREQ_LO:    rd_byte = freq_tub[7:0];
      rsec_pkg::IDX_FREQ_HI:    rd_byte = {4'h0, freq_tub[11:8]};
      rsec_pkg::IDX_EE_WPROT:   rd_byte = {7'h00, wprot};
      rsec_pkg::IDX_EE_COND:    rd_byte = {4'h0, cond};
      rsec_pkg::IDX_IRQ_STATUS: rd_byte = irq_status;
      rsec_pkg::IDX_IRQ_MASK:   rd_byte = irq_mask;
      default:                  hit     = 1'b0;
    endcase
  end

  // read data and error flag, captured in the setup phase
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      prdata <= '0;
      err    <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata <= {{(rsec_pkg::DATA_W-rsec_pkg::BYTE_W){1'b0}}, rd_byte};
      err    <= ~(aligned & hit);
    end
  end

  // per-reference status snapshot
  genvar g;
  generate
    for (g = 0; g < rsec_pkg::NUM_REF; g++)
    begin : g_ref
      assign live_valid[g] = i_ref_timer_done[g] & ~i_ref_fault[g];

      always_comb
      begin
        next_stat[g]                     = '0;
        next_stat[g][rsec_pkg::BIT_VALID] = live_valid[g];
        next_stat[g][rsec_pkg::BIT_FAULT] = i_ref_fault[g];
        // a missing clock forces both limit flags
        next_stat[g][rsec_pkg::BIT_FAST]  = i_ref_freq_high[g]
                                          | i_ref_clk_missing[g];
        next_stat[g][rsec_pkg::BIT_SLOW]  = i_ref_freq_low[g]
                                          | i_ref_clk_missing[g];
      end

      // frozen between strobes so a multi-byte read stays coherent
      always_ff @(posedge i_clk or posedge i_sys_rst)
      begin
        if (i_sys_rst)
          ref_stat[g] <= '0;
        else if (io_update)
          ref_stat[g] <= next_stat[g];
      end

      // edge detectors feeding the sticky events
      always_ff @(posedge i_clk or posedge i_sys_rst)
      begin
        if (i_sys_rst)
        begin
          prev_valid[g] <= 1'b0;
          prev_fault[g] <= 1'b0;
        end
        else
        begin
          prev_valid[g] <= live_valid[g];
          prev_fault[g] <= i_ref_fault[g];
        end
      end

      assign irq_set[g] = i_ref_fault[g] & ~prev_fault[g];
      assign irq_set[g+rsec_pkg::IRQ_VAL_LSB] =
        live_valid[g] & ~prev_valid[g];
    end
  endgenerate

  // live readbacks, one cycle behind the source
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      tune      <= '0;
      phase_tub <= '0;
      freq_tub  <= '0;
    end
    else
    begin
      tune      <= i_tuning_word;
      phase_tub <= i_phase_tub;
      freq_tub  <= i_freq_tub;
    end
  end

  // eeprom controls act at once, no update strobe
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      wprot <= rsec_pkg::WPROT_RESET;
    else if (wr_en && idx == rsec_pkg::IDX_EE_WPROT)
      wprot <= i_pwdata[rsec_pkg::WPROT_BIT];
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      cond <= rsec_pkg::COND_RESET;
    else if (wr_en && idx == rsec_pkg::IDX_EE_COND)
      cond <= i_pwdata[rsec_pkg::COND_W-1:0];
  end

  assign o_eeprom_write_enable       = wprot;
  assign o_eeprom_download_condition = cond;

  // sticky events, write one to clear; a set in the same cycle wins
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      irq_status <= rsec_pkg::IRQ_RESET;
    else if (wr_en && idx == rsec_pkg::IDX_IRQ_STATUS)
      irq_status <= (irq_status & ~i_pwdata[rsec_pkg::IRQ_W-1:0])
                  | irq_set;
    else
      irq_status <= irq_status | irq_set;
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      irq_mask <= rsec_pkg::IRQ_RESET;
    else if (wr_en && idx == rsec_pkg::IDX_IRQ_MASK)
      irq_mask <= i_pwdata[rsec_pkg::IRQ_W-1:0];
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_irq <= 1'b0;
    else
      o_irq <= |(irq_status & irq_mask);
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_write(logic [13:0] a);
    i_psel && i_penable && i_pwrite && aligned && i_pstrb[0]
      && idx == a;
  endsequence

  sequence s_read_setup(logic [13:0] a);
    i_psel && !i_penable && !i_pwrite && aligned && idx == a;
  endsequence

  AST_VALID_SNAP: assert property (
    io_update |=> ref_stat[0][rsec_pkg::BIT_VALID]
      == ($past(i_ref_timer_done[0]) && !$past(i_ref_fault[0])))
    else $error("valid flag does not follow timer and fault");

  AST_FAULT_SNAP: assert property (
    io_update && i_ref_fault[1] |=> ref_stat[1][rsec_pkg::BIT_FAULT]
      && !ref_stat[1][rsec_pkg::BIT_VALID])
    else $error("fault flag not captured");

  AST_FAST_SNAP: assert property (
    io_update && i_ref_freq_high[1] |=> ref_stat[1][rsec_pkg::BIT_FAST])
    else $error("fast flag not captured");

  AST_SLOW_SNAP: assert property (
    io_update && !i_ref_freq_low[3] && !i_ref_clk_missing[3]
      |=> !ref_stat[3][rsec_pkg::BIT_SLOW])
    else $error("slow flag set without cause");

  AST_MISSING_BOTH: assert property (
    io_update && i_ref_clk_missing[3]
      |=> ref_stat[3][rsec_pkg::BIT_FAST] && ref_stat[3][rsec_pkg::BIT_SLOW])
    else $error("missing clock not shown as fast and slow");

  AST_HOLD_NO_UPDATE: assert property (
    !io_update |=> $stable(ref_stat[0]) && $stable(ref_stat[3]))
    else $error("status changed without update strobe");

  AST_TUNE_TOP: assert property (
    s_read_setup(rsec_pkg::IDX_TUNE_B3) ##1 i_penable
      |-> prdata[7:0] == {2'h0, $past(tune[29:24])})
    else $error("tuning word top byte wrong");

  AST_PHASE_HI: assert property (
    s_read_setup(rsec_pkg::IDX_PHASE_HI)
      |=> prdata[7:4] == 4'h0 && prdata[3:0] == $past(phase_tub[11:8]))
    else $error("phase level high byte wrong");

  AST_FREQ_LO: assert property (
    s_read_setup(rsec_pkg::IDX_FREQ_LO) ##1 i_penable
      |-> prdata[7:0] == $past(freq_tub[7:0]))
    else $error("frequency level low byte wrong");

  AST_WPROT_LIVE: assert property (
    s_write(rsec_pkg::IDX_EE_WPROT)
      |=> o_eeprom_write_enable == $past(i_pwdata[0]))
    else $error("write protect not live");

  AST_COND_LIVE: assert property (
    s_write(rsec_pkg::IDX_EE_COND)
      |=> o_eeprom_download_condition == $past(i_pwdata[3:0])
      ##1 o_eeprom_download_condition == $past(i_pwdata[3:0], 2))
    else $error("download condition not held");

  AST_RSVD_ZERO: assert property (
    s_read_setup(rsec_pkg::IDX_EE_COND) |=> prdata[31:4] == '0)
    else $error("reserved bits not zero");

  // eeprom reset and hold, bus errors, readback bytes, strobe decode and interrupt bookkeeping
  sequence s_access;
    i_psel && i_penable;
  endsequence

  sequence s_fault_rise(int k);
    !i_ref_fault[k] ##1 i_ref_fault[k];
  endsequence

  AST_RESET_VALUES: assert property (
    $fell(i_sys_rst) |-> o_eeprom_write_enable == rsec_pkg::WPROT_RESET
      && o_eeprom_download_condition == rsec_pkg::COND_RESET)
    else $error("eeprom controls not at reset value");

  AST_WPROT_HOLD: assert property (
    !(access_ph && i_pwrite && idx == rsec_pkg::IDX_EE_WPROT)
      |=> $stable(o_eeprom_write_enable))
    else $error("write protect moved without a write");

  AST_COND_HOLD: assert property (
    !(access_ph && i_pwrite && idx == rsec_pkg::IDX_EE_COND)
      |=> $stable(o_eeprom_download_condition))
    else $error("download condition moved without a write");

  AST_UNMAPPED_ERR: assert property (
    i_psel && !i_penable && !hit ##1 s_access
      |-> o_pslverr && o_prdata == '0)
    else $error("unmapped access not refused");

  AST_TUNE_B0: assert property (
    s_read_setup(rsec_pkg::IDX_TUNE_B0) |=> prdata[7:0] == $past(tune[7:0]))
    else $error("tuning word low byte wrong");

  AST_PHASE_LO: assert property (
    s_read_setup(rsec_pkg::IDX_PHASE_LO)
      |=> prdata[7:0] == $past(phase_tub[7:0]))
    else $error("phase level low byte wrong");

  AST_FREQ_HI: assert property (
    s_read_setup(rsec_pkg::IDX_FREQ_HI)
      |=> prdata[7:0] == {4'h0, $past(freq_tub[11:8])})
    else $error("frequency level high byte wrong");

  AST_RD_UPPER_ZERO: assert property (
    o_prdata[rsec_pkg::DATA_W-1:rsec_pkg::BYTE_W] == '0)
    else $error("read data above the byte not zero");

  AST_UPDATE_NEEDS_ONE: assert property (
    s_write(rsec_pkg::IDX_IO_UPDATE) ##0 !i_pwdata[rsec_pkg::IO_UPDATE_BIT]
      |-> !o_io_update)
    else $error("update strobe without bit set");

  AST_UPDATE_STROBE: assert property (
    s_write(rsec_pkg::IDX_IO_UPDATE) ##0 i_pwdata[rsec_pkg::IO_UPDATE_BIT]
      |-> o_io_update)
    else $error("update strobe missing");

  // a same-cycle event must survive a clear
  AST_IRQ_SET_WINS: assert property (
    irq_set != '0 |=> (irq_status & $past(irq_set)) == $past(irq_set))
    else $error("interrupt event lost");

  AST_IRQ_W1C: assert property (
    s_write(rsec_pkg::IDX_IRQ_STATUS) ##0 irq_set == '0
      |=> (irq_status & $past(i_pwdata[7:0])) == '0)
    else $error("interrupt status not cleared");

  AST_IRQ_MASKED: assert property (
    irq_mask == '0 |=> !o_irq)
    else $error("masked interrupt raised");

  AST_IRQ_RAISE: assert property (
    (irq_status & irq_mask) != '0 |=> o_irq)
    else $error("unmasked interrupt not raised");

  AST_FAULT_EVENT: assert property (
    s_fault_rise(0) |=> irq_status[0])
    else $error("fault rise not recorded");

endmodule : rsec_regs

// ===== tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // clock, reset and apb master side
  logic                            clk     = 1'b0;
  logic                            rst     = 1'b1;
  logic                            psel    = 1'b0;
  logic                            penable = 1'b0;
  logic                            pwrite  = 1'b0;
  logic [rsec_pkg::ADDR_W-1:0]     paddr   = '0;
  logic [rsec_pkg::DATA_W-1:0]     pwdata  = '0;
  logic [3:0]                      pstrb   = 4'hF;
  logic [rsec_pkg::DATA_W-1:0]     prdata;
  logic                            pready;
  logic                            pslverr;
  // monitor inputs
  logic [rsec_pkg::NUM_REF-1:0]    ref_fault = '0;
  logic [rsec_pkg::NUM_REF-1:0]    ref_timer = '0;
  logic [rsec_pkg::NUM_REF-1:0]    ref_high  = '0;
  logic [rsec_pkg::NUM_REF-1:0]    ref_low   = '0;
  logic [rsec_pkg::NUM_REF-1:0]    ref_miss  = '0;
  logic [rsec_pkg::TUNE_W-1:0]     tune      = '0;
  logic [rsec_pkg::TUB_W-1:0]      ptub      = '0;
  logic [rsec_pkg::TUB_W-1:0]      ftub      = '0;
  // outputs
  logic                            ee_we;
  logic [rsec_pkg::COND_W-1:0]     ee_cond;
  logic                            io_upd;
  logic                            irq;
  // bookkeeping
  int                              errors   = 0;
  int                              n_checks = 0;
  logic [31:0]                     rdat;
  logic                            rerr;
  int                              n_upd    = 0;

  always #2.5 clk = ~clk;

  // count update strobes the design shows at each edge
  always @(posedge clk)
  begin
    if (io_upd === 1'b1)
      n_upd <= n_upd + 1;
  end

  rsec_regs DUT
  (
    .i_clk                       (clk),
    .i_sys_rst                   (rst),
    .i_psel                      (psel),
    .i_penable                   (penable),
    .i_pwrite                    (pwrite),
    .i_paddr                     (paddr),
    .i_pwdata                    (pwdata),
    .i_pstrb                     (pstrb),
    .o_prdata                    (prdata),
    .o_pready                    (pready),
    .o_pslverr                   (pslverr),
    .i_ref_fault                 (ref_fault),
    .i_ref_timer_done            (ref_timer),
    .i_ref_freq_high             (ref_high),
    .i_ref_freq_low              (ref_low),
    .i_ref_clk_missing           (ref_miss),
    .i_tuning_word               (tune),
    .i_phase_tub                 (ptub),
    .i_freq_tub                  (ftub),
    .o_eeprom_write_enable       (ee_we),
    .o_eeprom_download_condition (ee_cond),
    .o_io_update                 (io_upd),
    .o_irq                       (irq)
  );

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one transfer; waits for pready with a bound, never assumes latency
  task automatic apb(input logic wr, input logic [13:0] idx,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'h0};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, pready, 1'b1);
      give_verdict();
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [13:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rdat, exp);
  endtask : rd_chk

  task automatic set_refs(input logic [3:0] f, t, h, l, m);
    @(posedge clk);
    ref_fault <= f;
    ref_timer <= t;
    ref_high  <= h;
    ref_low   <= l;
    ref_miss  <= m;
  endtask : set_refs

  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_chk(rsec_pkg::IDX_EE_WPROT, 32'h0);
    rd_chk(rsec_pkg::IDX_EE_COND, 32'h0);
    chk({31'h0, ee_we}, 32'h0);
    // live bits, reserved bits dropped
    apb(1'b1, rsec_pkg::IDX_EE_WPROT, 32'hFF);
    rd_chk(rsec_pkg::IDX_EE_WPROT, 32'h1);
    chk({31'h0, ee_we}, 32'h1);
    pstrb <= 4'h0;
    apb(1'b1, rsec_pkg::IDX_EE_WPROT, 32'h0);
    pstrb <= 4'hF;
    rd_chk(rsec_pkg::IDX_EE_WPROT, 32'h1);
    apb(1'b1, rsec_pkg::IDX_EE_WPROT, 32'h0);
    rd_chk(rsec_pkg::IDX_EE_WPROT, 32'h0);
    chk({31'h0, ee_we}, 32'h0);
    apb(1'b1, rsec_pkg::IDX_EE_COND, 32'hA5);
    rd_chk(rsec_pkg::IDX_EE_COND, 32'h5);
    chk({28'h0, ee_cond}, 32'h5);
    // unmapped index refused
    apb(1'b0, 14'h0100, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    // interrupt raise, mask, clear
    apb(1'b1, rsec_pkg::IDX_IRQ_MASK, 32'h1);
    set_refs(4'h1, 4'h0, 4'h0, 4'h0, 4'h0);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    set_refs(4'h3, 4'h0, 4'h0, 4'h0, 4'h0);
    rd_chk(rsec_pkg::IDX_IRQ_STATUS, 32'h3);
    apb(1'b1, rsec_pkg::IDX_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, rsec_pkg::IDX_IRQ_STATUS, 32'h3);
    apb(1'b1, rsec_pkg::IDX_IRQ_MASK, 32'h3);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rd_chk(rsec_pkg::IDX_IRQ_STATUS, 32'h0);
    // a valid, b fault fast, c valid slow, d fault missing
    set_refs(4'hA, 4'hD, 4'h2, 4'h4, 4'h8);
    rd_chk(rsec_pkg::IDX_REF_AB, 32'h0);
    apb(1'b1, rsec_pkg::IDX_IO_UPDATE, 32'h1);
    rd_chk(rsec_pkg::IDX_REF_AB, 32'h68);
    rd_chk(rsec_pkg::IDX_REF_CD, 32'h79);
    set_refs(4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
    apb(1'b1, rsec_pkg::IDX_IO_UPDATE, 32'h0);
    rd_chk(rsec_pkg::IDX_REF_AB, 32'h68);
    apb(1'b1, rsec_pkg::IDX_REF_AB, 32'hFE);
    rd_chk(rsec_pkg::IDX_REF_AB, 32'h68);
    apb(1'b1, rsec_pkg::IDX_IO_UPDATE, 32'h1);
    rd_chk(rsec_pkg::IDX_REF_AB, 32'h0);
    rd_chk(rsec_pkg::IDX_REF_CD, 32'h0);
    chk(n_upd, 32'h2);
    // top tuning bits and reserved tub nibbles must read zero
    @(posedge clk);
    tune <= 30'h3FEDCBA9;
    ptub <= 12'hABC;
    ftub <= 12'h5E7;
    rd_chk(rsec_pkg::IDX_TUNE_B0, 32'hA9);
    rd_chk(rsec_pkg::IDX_TUNE_B1, 32'hCB);
    rd_chk(rsec_pkg::IDX_TUNE_B2, 32'hED);
    rd_chk(rsec_pkg::IDX_TUNE_B3, 32'h3F);
    rd_chk(rsec_pkg::IDX_PHASE_LO, 32'hBC);
    rd_chk(rsec_pkg::IDX_PHASE_HI, 32'h0A);
    rd_chk(rsec_pkg::IDX_FREQ_LO, 32'hE7);
    rd_chk(rsec_pkg::IDX_FREQ_HI, 32'h05);
    // mid-run reset returns the live controls to their defaults
    apb(1'b1, rsec_pkg::IDX_EE_WPROT, 32'h1);
    @(posedge clk);
    chk({31'h0, ee_we}, 32'h1);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    chk({31'h0, ee_we}, 32'h0);
    chk({28'h0, ee_cond}, 32'h0);
    rd_chk(rsec_pkg::IDX_EE_WPROT, 32'h0);
    rd_chk(rsec_pkg::IDX_EE_COND, 32'h0);
    give_verdict();
  end
endmodule : tb_top
